/* design/spi_port_pkg.sv */
// Constants shared by both ends of the serial link: register map, field positions,
// clocking modes and divider counts.
// Assumes one 100 MHz core clock on both ends and an active-high asynchronous reset.
package spi_port_pkg;
  localparam int DATA_W = 8;

  // Register port offsets
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTRL1  = 3'h1;
  localparam logic [2:0] ADDR_CTRL3  = 3'h2;
  localparam logic [2:0] ADDR_DATA   = 3'h3;
  localparam logic [2:0] ADDR_RATE   = 3'h4;
  localparam logic [2:0] ADDR_FLAG   = 3'h5;

  // port_status_reg fields
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF  = 0;
  // port_control_one fields
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OVF  = 6;
  localparam int CTL_EN   = 5;
  localparam int CTL_CKP  = 4;
  // port_control_three field
  localparam int C3_BOEN  = 4;
  // Flag register field
  localparam int FLAG_IRQ = 0;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL3_RST  = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h00;

  // Clocking modes
  localparam logic [3:0] MODE_HOST_DIV4   = 4'h0;
  localparam logic [3:0] MODE_HOST_DIV16  = 4'h1;
  localparam logic [3:0] MODE_HOST_DIV64  = 4'h2;
  localparam logic [3:0] MODE_HOST_TIMER  = 4'h3;
  localparam logic [3:0] MODE_CLIENT_SS   = 4'h4;
  localparam logic [3:0] MODE_CLIENT_FREE = 4'h5;
  localparam logic [3:0] MODE_HOST_RATE   = 4'hA;

  // Half periods of the serial clock, in core clocks
  localparam logic [9:0] HALF_DIV4  = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;

  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

/* design/spi_link_if.sv */
// Serial link between the port and its far party: clock, two data lines, select.
// Clock and select carry an output and an enable per end, each data line one from its sending end; the resolved levels live here.
interface spi_link_if;
  logic dev_sck;
  logic dev_sck_oe;
  logic far_sck;
  logic far_sck_oe;
  logic dev_sdo;
  logic dev_sdo_oe;
  logic far_sdo;
  logic far_sdo_oe;
  logic dev_ss_n;
  logic dev_ss_oe;
  logic far_ss_n;
  logic far_ss_oe;
  logic sck;
  logic ss_n;
  logic dev_sdi;
  logic far_sdi;

  // Undriven select floats high through a pull-up; undriven data reads high
  assign sck     = dev_sck_oe ? dev_sck : (far_sck_oe ? far_sck : 1'b0);
  assign ss_n    = dev_ss_oe ? dev_ss_n : (far_ss_oe ? far_ss_n : 1'b1);
  assign dev_sdi = far_sdo_oe ? far_sdo : 1'b1;
  assign far_sdi = dev_sdo_oe ? dev_sdo : 1'b1;

  modport dev (output dev_sck, dev_sck_oe, dev_sdo, dev_sdo_oe, dev_ss_n, dev_ss_oe,
               input  sck, ss_n, dev_sdi);
  modport far (output far_sck, far_sck_oe, far_sdo, far_sdo_oe, far_ss_n, far_ss_oe,
               input  sck, ss_n, far_sdi);
endinterface

/* design/spi_port.sv */
// Synchronous serial port, SPI mode: host or client end with its software registers.
// Assumes link pins synchronous to core_clk_i and a register master that never waits.
//
// Overview of operation
// - Eight-bit shift register, MSb out, LSb in
// - Shift on configured edge, capture on opposite
// - One bit each way per clock cycle
// - After eight bits, contents exchanged; reload needed
// - Host clocks whole bytes, then stops, deselects
// - Unselected client ignores link, drives no data
// - Host starts with MSb and clock
// - Both ends use same clock polarity
// - Host selects at most one client
// - Full byte goes to buffer, sets flag
// - Buffer write loads shift register too
// - Shift register reached only through buffer
// - Status: low six read-only, upper two writable
// - First control register fully read/write
// - One host mode uses rate reload divider
// - Write while busy dropped, sets collision flag
// - Buffer full set on receive, cleared on read
// - Port runs only while enable bit set
// - Edge select chooses output change edge
module spi_port (
  input  wire logic                            core_clk_i,
  input  wire logic                            reset_i,
  input  wire logic [2:0]                      reg_addr_i,
  input  wire logic [spi_port_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output logic      [spi_port_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic                            timer_tick_i,
  output logic                                 irq_flag_o,
  spi_link_if.dev                              link
);
  import spi_port_pkg::*;

  logic [7:0] status_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl3_reg;
  logic [7:0] rate_reg;
  logic [7:0] data_buffer_reg;
  logic [7:0] serial_shift_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic       active_reg;
  logic       tail_reg;
  logic       phase_reg;
  logic [9:0] div_reg;
  logic       sck_prev_reg;
  logic [2:0] bit_reg;
  logic       sample_reg;
  logic       sdo_reg;

  logic       enable;
  logic       cke;
  logic       host_mode;
  logic       client_mode;
  logic       selected;
  logic       busy;
  logic       data_wr;
  logic       load;
  logic [9:0] half_len;
  logic       host_tick;
  logic       edge_lead;
  logic       edge_trail;
  logic       cap_trail;
  logic       byte_done;
  logic [7:0] rx_byte;

  assign enable      = ctrl1_reg[CTL_EN];
  assign cke         = status_reg[STAT_CKE];
  assign host_mode   = enable && (ctrl1_reg[3:0] inside {MODE_HOST_DIV4, MODE_HOST_DIV16, MODE_HOST_DIV64,
                                                        MODE_HOST_TIMER, MODE_HOST_RATE});
  assign client_mode = enable && (ctrl1_reg[3:0] inside {MODE_CLIENT_SS, MODE_CLIENT_FREE});
  assign selected    = client_mode && (ctrl1_reg[3:0] == MODE_CLIENT_FREE || !link.ss_n);
  assign busy        = host_mode ? (active_reg || tail_reg) : (bit_reg != 3'h0);
  assign data_wr     = reg_wr_i && reg_addr_i == ADDR_DATA;
  assign load        = data_wr && !busy && !ctrl1_reg[CTL_WRITE_COLLISION_FLAG];

  always_comb begin
    case (ctrl1_reg[3:0])
      MODE_HOST_DIV16: half_len = HALF_DIV16;
      MODE_HOST_DIV64: half_len = HALF_DIV64;
      MODE_HOST_RATE:  half_len = {1'b0, rate_reg, 1'b0} + 10'h002;
      default:         half_len = HALF_DIV4;
    endcase
  end

  // Timer mode halves the timer rate: each tick is one half period
  assign host_tick = active_reg && ((ctrl1_reg[3:0] == MODE_HOST_TIMER) ? timer_tick_i
                                                                         : (div_reg == half_len - 10'h001));

  // Leading edge goes idle-to-active, trailing edge active-to-idle
  always_comb begin
    edge_lead  = 1'b0;
    edge_trail = 1'b0;
    if (host_mode) begin
      edge_lead  = host_tick && !phase_reg;
      edge_trail = host_tick && phase_reg;
    end else if (selected) begin
      edge_lead  = (link.sck ^ ctrl1_reg[CTL_CKP]) && !(sck_prev_reg ^ ctrl1_reg[CTL_CKP]);
      edge_trail = !(link.sck ^ ctrl1_reg[CTL_CKP]) && (sck_prev_reg ^ ctrl1_reg[CTL_CKP]);
    end
  end

  // Late sampling only makes sense for a host with early data
  assign cap_trail = !cke || (host_mode && status_reg[STAT_SMP]);
  assign byte_done = edge_trail && bit_reg == LAST_BIT;
  assign rx_byte   = {serial_shift_reg[6:0], cap_trail ? link.dev_sdi : sample_reg};

  // Host clock generator
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_reg <= 1'b0;
      phase_reg  <= 1'b0;
      div_reg    <= 10'h000;
    end else if (!host_mode) begin
      active_reg <= 1'b0;
      phase_reg  <= 1'b0;
      div_reg    <= 10'h000;
    end else if (load) begin
      active_reg <= 1'b1;
      phase_reg  <= 1'b0;
      div_reg    <= 10'h000;
    end else if (active_reg) begin
      div_reg <= host_tick ? 10'h000 : div_reg + 10'h001;
      if (host_tick) begin
        phase_reg <= !phase_reg;
        if (byte_done) begin
          active_reg <= 1'b0;
        end
      end
    end
  end

  // Select outlasts the last clock edge by one cycle so a registered client still sees that edge
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tail_reg <= 1'b0;
    end else begin
      tail_reg <= host_mode && byte_done;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= link.sck;
    end
  end

  // Shift engine shared by host and client
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      serial_shift_reg <= 8'h00;
      bit_reg          <= 3'h0;
      sample_reg       <= 1'b0;
      sdo_reg          <= 1'b0;
    end else if (load) begin
      serial_shift_reg <= reg_wdata_i;
      sdo_reg          <= reg_wdata_i[7];
      bit_reg          <= 3'h0;
    end else if (!host_mode && !selected) begin
      bit_reg <= 3'h0;
    end else begin
      if (edge_lead) begin
        sample_reg <= link.dev_sdi;
        if (!cke) begin
          sdo_reg <= serial_shift_reg[7];
        end
      end
      if (edge_trail) begin
        serial_shift_reg <= rx_byte;
        bit_reg          <= bit_reg + 3'h1;
        if (cke) begin
          sdo_reg <= serial_shift_reg[6];
        end
      end
    end
  end

  // Software registers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_reg <= STATUS_RST;
      ctrl1_reg  <= CTRL1_RST;
      ctrl3_reg  <= CTRL3_RST;
      rate_reg   <= RATE_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_STATUS) begin
        status_reg[7:6] <= reg_wdata_i[7:6];
      end
      if (reg_wr_i && reg_addr_i == ADDR_CTRL1) begin
        ctrl1_reg <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == ADDR_CTRL3) begin
        ctrl3_reg <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == ADDR_RATE) begin
        rate_reg <= reg_wdata_i;
      end
      // Hardware sets after the software write so an event never gets lost
      if (data_wr && (busy || ctrl1_reg[CTL_WRITE_COLLISION_FLAG])) begin
        ctrl1_reg[CTL_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (byte_done && status_reg[STAT_BF] && !ctrl3_reg[C3_BOEN]) begin
        ctrl1_reg[CTL_OVF] <= 1'b1;
      end
      if (reg_rd_i && reg_addr_i == ADDR_DATA) begin
        status_reg[STAT_BF] <= 1'b0;
      end
      if (byte_done && (!status_reg[STAT_BF] || ctrl3_reg[C3_BOEN])) begin
        status_reg[STAT_BF] <= 1'b1;
      end
    end
  end

  // Unread byte is kept unless overwrite is enabled
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_buffer_reg <= 8'h00;
    end else if (load) begin
      data_buffer_reg <= reg_wdata_i;
    end else if (byte_done && (!status_reg[STAT_BF] || ctrl3_reg[C3_BOEN])) begin
      data_buffer_reg <= rx_byte;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else if (byte_done) begin
      irq_reg <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == ADDR_FLAG && !reg_wdata_i[FLAG_IRQ]) begin
      irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_STATUS: rdata_reg <= status_reg;
        ADDR_CTRL1:  rdata_reg <= ctrl1_reg;
        ADDR_CTRL3:  rdata_reg <= ctrl3_reg;
        ADDR_DATA:   rdata_reg <= data_buffer_reg;
        ADDR_RATE:   rdata_reg <= rate_reg;
        ADDR_FLAG:   rdata_reg <= {7'h00, irq_reg};
        default:     rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_o     = rdata_reg;
  assign irq_flag_o      = irq_reg;
  assign link.dev_sck    = ctrl1_reg[CTL_CKP] ^ (active_reg && phase_reg);
  assign link.dev_sck_oe = host_mode;
  assign link.dev_sdo    = sdo_reg;
  assign link.dev_sdo_oe = host_mode || selected;
  // Only one select line, so only one client can ever be addressed
  assign link.dev_ss_n   = !(active_reg || tail_reg);
  assign link.dev_ss_oe  = host_mode;
endmodule

/* design/spi_partner.sv */
// Far party of the serial link: an SPI host or a single client, chosen by role_host_i.
// Assumes the same core clock as the port and that the two roles are never both host.
module spi_partner #(
  parameter int HALF_CYCLES = 4
) (
  input  wire logic                            core_clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            role_host_i,
  input  wire logic                            ckp_i,
  input  wire logic                            cke_i,
  input  wire logic                            start_i,
  input  wire logic [spi_port_pkg::DATA_W-1:0] tx_byte_i,
  output logic      [spi_port_pkg::DATA_W-1:0] rx_byte_o,
  output logic                                 rx_valid_o,
  output logic                                 busy_o,
  spi_link_if.far                              link
);
  import spi_port_pkg::*;

  if (HALF_CYCLES < 1 || HALF_CYCLES > 1023) begin : half_check
    $error("HALF_CYCLES out of range");
  end

  localparam logic [9:0] HALF_LAST = 10'(HALF_CYCLES - 1);

  // Hold keeps the select low one cycle past the last edge for a registered client
  typedef enum {ST_IDLE, ST_LEAD, ST_TRAIL, ST_HOLD} host_state_t;

  host_state_t state_reg;
  logic [9:0]  div_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_reg;
  logic        sample_reg;
  logic        sdo_reg;
  logic        sck_prev_reg;
  logic [7:0]  rx_reg;
  logic        valid_reg;
  logic        edge_lead;
  logic        edge_trail;
  logic        selected;
  logic        load;

  assign selected = !role_host_i && !link.ss_n;
  assign load     = start_i && !busy_o;

  always_comb begin
    edge_lead  = 1'b0;
    edge_trail = 1'b0;
    if (role_host_i) begin
      edge_lead  = state_reg == ST_LEAD && div_reg == HALF_LAST;
      edge_trail = state_reg == ST_TRAIL && div_reg == HALF_LAST;
    end else if (selected) begin
      edge_lead  = (link.sck ^ ckp_i) && !(sck_prev_reg ^ ckp_i);
      edge_trail = !(link.sck ^ ckp_i) && (sck_prev_reg ^ ckp_i);
    end
  end

  // Host sequencer: exactly eight clock pulses per started byte
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      div_reg   <= 10'h000;
    end else if (!role_host_i) begin
      state_reg <= ST_IDLE;
      div_reg   <= 10'h000;
    end else begin
      div_reg <= (state_reg == ST_IDLE || div_reg == HALF_LAST) ? 10'h000 : div_reg + 10'h001;
      case (state_reg)
        ST_IDLE: begin
          if (start_i) begin
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (edge_lead) begin
            state_reg <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (edge_trail) begin
            state_reg <= (bit_reg == LAST_BIT) ? ST_HOLD : ST_LEAD;
          end
        end
        ST_HOLD: begin
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= link.sck;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg  <= 8'h00;
      bit_reg    <= 3'h0;
      sample_reg <= 1'b0;
      sdo_reg    <= 1'b0;
    end else if (load) begin
      shift_reg <= tx_byte_i;
      sdo_reg   <= tx_byte_i[7];
      bit_reg   <= 3'h0;
    end else if (!role_host_i && !selected) begin
      bit_reg <= 3'h0;
    end else begin
      if (edge_lead) begin
        sample_reg <= link.far_sdi;
        if (!cke_i) begin
          sdo_reg <= shift_reg[7];
        end
      end
      if (edge_trail) begin
        shift_reg <= {shift_reg[6:0], cke_i ? sample_reg : link.far_sdi};
        bit_reg   <= bit_reg + 3'h1;
        if (cke_i) begin
          sdo_reg <= shift_reg[6];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_reg    <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= edge_trail && bit_reg == LAST_BIT;
      if (edge_trail && bit_reg == LAST_BIT) begin
        rx_reg <= {shift_reg[6:0], cke_i ? sample_reg : link.far_sdi};
      end
    end
  end

  assign busy_o          = role_host_i ? (state_reg != ST_IDLE) : (bit_reg != 3'h0);
  assign rx_byte_o       = rx_reg;
  assign rx_valid_o      = valid_reg;
  assign link.far_sck    = ckp_i ^ (state_reg == ST_TRAIL);
  assign link.far_sck_oe = role_host_i;
  assign link.far_sdo    = sdo_reg;
  assign link.far_sdo_oe = role_host_i || selected;
  assign link.far_ss_n   = state_reg == ST_IDLE;
  assign link.far_ss_oe  = role_host_i;
endmodule

/* sim/spi_link_asserts.sv */
// Checker on the resolved link between port and partner: clock, select, data drive.
// Assumes one core clock for both ends and the resolved levels of spi_link_if.
module spi_link_asserts (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic dev_sck,
  input wire logic dev_sck_oe,
  input wire logic far_sck_oe,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe,
  input wire logic far_sdo_oe
);
  logic       sck_q;
  logic [5:0] edge_cnt;
  logic [5:0] edge_now;

  // Edge in the deselect cycle itself still belongs to the frame
  assign edge_now = edge_cnt + {5'h00, sck != sck_q};

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_q    <= 1'b0;
      edge_cnt <= 6'h00;
    end else begin
      sck_q    <= sck;
      edge_cnt <= ss_n ? 6'h00 : edge_now;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // Registered ends may move data up to two cycles after the clock edge
  sequence edge_recent;
    $changed(sck) || ($past(sck) != $past(sck, 2)) || ($past(sck, 2) != $past(sck, 3));
  endsequence

  a_dev_quiet_unsel: assert property (ss_n && $past(ss_n) && !dev_sck_oe |-> !dev_sdo_oe)
    else $error("port drives data while not selected");
  a_far_quiet_unsel: assert property (ss_n && $past(ss_n) && !far_sck_oe |-> !far_sdo_oe)
    else $error("partner drives data while not selected");
  a_host_sck_idle: assert property (dev_sck_oe && $past(dev_sck_oe) && ss_n && $past(ss_n)
    |-> $stable(dev_sck))
    else $error("idle host clock moved");
  a_whole_bytes: assert property ($rose(ss_n) |-> edge_now == 6'h10)
    else $error("frame not sixteen clock edges");
  a_one_clock: assert property (!(dev_sck_oe && far_sck_oe))
    else $error("both ends drive the clock");
  a_sel_clocked: assert property (!ss_n |-> dev_sck_oe || far_sck_oe)
    else $error("select low with no clock driver");
  a_duplex_drive: assert property (!ss_n && !$past(ss_n) && !$past(ss_n, 2)
    |-> far_sdo_oe && (dev_sdo_oe || !dev_sck_oe))
    else $error("data line undriven in frame");
  a_sdo_on_edge: assert property ($changed(dev_sdo) && dev_sdo_oe && $past(dev_sdo_oe) && !ss_n
    && !$past(ss_n) |-> edge_recent)
    else $error("port data moved away from a clock edge");
endmodule

/* sim/spi_port_tb.sv */
// Bench joining port and partner by the link; software side driven through registers.
// Assumes reads answer one cycle after the strobe and the register port never stalls.
module spi_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_port_pkg::*;

  logic       core_clk_i, reset_i, reg_wr, reg_rd, tick, irq;
  logic       role_host, clock_polarity_select, cke, start, busy, rx_valid;
  logic [1:0] tick_cnt;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, far_tx, far_rx, rx_cnt;
  int         bad_count, tests_run;

  spi_link_if link ();
  spi_port i_spi_port (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .timer_tick_i(tick), .irq_flag_o(irq), .link(link));
  spi_partner #(.HALF_CYCLES(4)) i_spi_partner (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .role_host_i(role_host), .ckp_i(clock_polarity_select), .cke_i(cke), .start_i(start), .tx_byte_i(far_tx),
    .rx_byte_o(far_rx), .rx_valid_o(rx_valid), .busy_o(busy), .link(link));
  spi_link_asserts i_spi_link_asserts (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .sck(link.sck), .ss_n(link.ss_n), .dev_sck(link.dev_sck), .dev_sck_oe(link.dev_sck_oe),
    .far_sck_oe(link.far_sck_oe), .dev_sdo(link.dev_sdo), .dev_sdo_oe(link.dev_sdo_oe),
    .far_sdo_oe(link.far_sdo_oe));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Timer tick every third core clock
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      tick_cnt <= 2'h0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
      tick     <= (tick_cnt == 2'h2);
    end
  end

  // Bytes finished by the partner, in either role
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_cnt <= 8'h00;
    end else if (rx_valid) begin
      rx_cnt <= rx_cnt + 8'h01;
    end
  end

  task automatic report_and_stop;
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1 check(name, exp, reg_rdata);
  endtask

  task automatic far_start(input logic [7:0] b);
    @(posedge core_clk_i);
    far_tx <= b;
    start  <= 1'b1;
    @(posedge core_clk_i);
    start <= 1'b0;
  endtask

  // A wait that runs out counts as a mismatch
  task automatic wait_done(input logic far);
    int n;
    n = 0;
    #1;
    while (n < 3000 && (far ? busy !== 1'b0 : irq !== 1'b1)) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n == 3000) begin
      bad_count++;
      $display("Error wait_done expected done seen timeout");
    end
  endtask

  task automatic next_edge(output logic [7:0] n);
    logic s;
    #1 s = link.sck;
    for (n = 8'h00; n < 8'hC8 && link.sck === s; n++) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask

  task automatic xfer(input logic [3:0] mode, input logic c_ke, input logic c_kp, input logic [7:0] half,
                      input logic [7:0] dev_b, input logic [7:0] far_b, input logic collide);
    logic [7:0] n;
    logic       b;
    clock_polarity_select <= c_kp;
    cke <= c_ke;
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_STATUS, {c_ke & c_kp, c_ke, 6'h00});
    wr(ADDR_CTRL1, {3'b001, c_kp, mode});
    far_start(far_b);
    #1 check("sck idle", {7'h00, c_kp}, {7'h00, link.sck});
    wr(ADDR_DATA, dev_b);
    if (collide) wr(ADDR_DATA, ~dev_b);
    next_edge(n);
    b = link.far_sdi;
    next_edge(n);
    if (!c_ke) b = link.far_sdi;
    check("first bit", {7'h00, dev_b[7]}, {7'h00, b});
    check("half period", half, n);
    wait_done(1'b0);
    rdc("status full", ADDR_STATUS, {c_ke & c_kp, c_ke, 6'h01});
    rdc("irq flag", ADDR_FLAG, 8'h01);
    rdc("rx byte", ADDR_DATA, far_b);
    rdc("status read", ADDR_STATUS, {c_ke & c_kp, c_ke, 6'h00});
    check("far rx", dev_b, far_rx);
    if (collide) rdc("collision", ADDR_CTRL1, {3'b101, c_kp, mode});
    wr(ADDR_FLAG, 8'h00);
    #1 check("irq clear", 8'h00, {7'h00, irq});
  endtask

  logic [3:0] modes [5] = '{MODE_HOST_DIV4, MODE_HOST_DIV16, MODE_HOST_DIV64, MODE_HOST_TIMER, MODE_HOST_RATE};
  logic [7:0] halves [5] = '{8'h02, 8'h08, 8'h20, 8'h03, 8'h04};
  logic [7:0] dev_bs [5] = '{8'hA5, 8'h3C, 8'h96, 8'h0F, 8'hE1};
  logic [4:0] kes = 5'b01010;
  logic [4:0] kps = 5'b01100;
  logic [2:0] ra [5] = '{ADDR_STATUS, ADDR_CTRL1, ADDR_CTRL3, ADDR_RATE, ADDR_FLAG};
  logic [7:0] rv [5] = '{STATUS_RST, CTRL1_RST, CTRL3_RST, RATE_RST, 8'h00};

  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    {reg_wr, reg_rd, role_host, clock_polarity_select, cke, start} = 6'h00;
    {reg_addr, reg_wdata, far_tx} = 19'h00000;
    bad_count = 0;
    tests_run = 0;
    reset_i   = 1'b1;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 5; i++) rdc("reset value", ra[i], rv[i]);
    rdc("unmapped", 3'h7, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rdc("status access", ADDR_STATUS, 8'hC0);
    wr(ADDR_CTRL1, 8'hCF);
    rdc("ctrl1 access", ADDR_CTRL1, 8'hCF);
    wr(ADDR_CTRL3, 8'h10);
    rdc("ctrl3 access", ADDR_CTRL3, 8'h10);
    wr(ADDR_CTRL3, 8'h00);
    wr(ADDR_RATE, 8'h01);
    rdc("rate access", ADDR_RATE, 8'h01);
    for (int i = 0; i < 5; i++) xfer(modes[i], kes[i], kps[i], halves[i], dev_bs[i], ~dev_bs[i], i == 2);
    // Device as selected client, partner as host
    wr(ADDR_CTRL1, 8'h00);
    clock_polarity_select <= 1'b1;
    cke <= 1'b0;
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL1, {3'b001, 1'b1, MODE_CLIENT_SS});
    @(posedge core_clk_i);
    role_host <= 1'b1;
    wr(ADDR_DATA, 8'h81);
    far_start(8'h42);
    wait_done(1'b1);
    check("far rx client", 8'h81, far_rx);
    rdc("client rx", ADDR_DATA, 8'h42);
    far_start(8'h24);
    wait_done(1'b1);
    far_start(8'h99);
    wait_done(1'b1);
    rdc("kept byte", ADDR_DATA, 8'h24);
    rdc("overflow", ADDR_CTRL1, 8'h74);
    far_start(8'h5A);
    wait_done(1'b1);
    wr(ADDR_CTRL3, 8'h10);
    far_start(8'hC3);
    wait_done(1'b1);
    rdc("overwrite", ADDR_DATA, 8'hC3);
    check("rx pulses", 8'h0A, rx_cnt);
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_FLAG, 8'h00);
    far_start(8'h55);
    wait_done(1'b1);
    check("disabled sdo", 8'hFF, far_rx);
    check("disabled irq", 8'h00, {7'h00, irq});
    report_and_stop();
  end
endmodule
